//--- rtl/asp_map.vh
`ifndef ASP_MAP_VH
`define ASP_MAP_VH

// Register byte offsets on the APB side.
`define ASP_OFF_CTRL 8'h00
`define ASP_OFF_BUF 8'h04
`define ASP_OFF_RATE 8'h08
`define ASP_OFF_STAT 8'h0C

// Fields of serial_control_reg.
`define ASP_CTRL_RX_DONE 0
`define ASP_CTRL_TX_DONE 1
`define ASP_CTRL_RX_NINTH 2
`define ASP_CTRL_TX_NINTH 3
`define ASP_CTRL_REN 4
`define ASP_CTRL_FILTER 5
`define ASP_CTRL_MODE_LO 6
`define ASP_CTRL_MODE_HI 7

// Fields of the rate register.
`define ASP_RATE_DOUBLE 0
`define ASP_RATE_TX_SRC 1
`define ASP_RATE_RX_SRC 2

// Fields of the status register.
`define ASP_STAT_TXBUSY 0
`define ASP_STAT_RXBUSY 1

// Operating modes.
`define ASP_MODE_0 2'b00
`define ASP_MODE_1 2'b01
`define ASP_MODE_2 2'b10
`define ASP_MODE_3 2'b11

// Reset values.
`define ASP_MODE_RST 2'b00
`define ASP_BUF_RST 8'h00
`define ASP_RD_RST 32'h00000000
`define ASP_TSR_RST 9'h000
`define ASP_SAMP_RST 3'h7

// Bit timing constants.
`define ASP_CNT_LAST 4'hF
`define ASP_CNT_ZERO 4'h0
`define ASP_SAMPLE_A 4'h7
`define ASP_SAMPLE_B 4'h8
`define ASP_SAMPLE_C 4'h9
`define ASP_PRE_LAST 2'h3
`define ASP_RSR_INIT 9'h1FF
`define ASP_TX_END_PAT 8'h01

`endif

//--- rtl/asp_serial_port.v
// Notes on behaviour
// - Mode 1 frame: low start, eight data bits LSB first, high stop.
// - Mode 1 receive puts the stop bit into received_ninth_bit.
// - Modes 2/3 frame: start, eight data LSB first, transmit_ninth_bit, stop.
// - Mode 2 rate is oscillator divided by 32 or 64.
// - Mode 3 rate from timer 1 or 2 overflow, per direction.
// - Mode 1 buffer write loads a one as ninth bit and requests send.
// - Modes 2/3 buffer write loads transmit_ninth_bit as ninth bit, requests send.
// - Transmission starts at the next divide-by-16 rollover after the write.
// - Start bit first, shift register output one bit later, shift after that.
// - Modes 2/3 first shift inserts a one at bit nine, then zeros.
// - Mode 1 ends at tenth rollover: last shift, send off, transmit flag set.
// - Modes 2/3 end at eleventh rollover with the same actions.
// - Receiver samples at sixteen times bit rate with a sixteen-state counter.
// - Falling edge resets the counter and loads 1FF into the shift register.
// - Samples at counter states 7, 8, 9 with two-of-three majority vote.
// - Nonzero first bit aborts to edge search; valid start continues.
// - Nine-bit left shift register; start bit at top triggers final shift.
// - Mode 1 load only if receive flag clear and filter off or stop one.
// - Modes 2/3 load only if flag clear and filter off or ninth one.
// - Failed condition drops the frame, buffer and flags untouched.
// - Modes 2/3 ninth bit to flag, data to buffer, stop ignored.
// - Edge search resumes at final shift (mode 1) or one bit later.
// - Interrupt is OR of receive and transmit flags, never auto-cleared.
// - rate_double_bit resets to zero giving divide by 64.
`timescale 1ns/100ps
`include "asp_map.vh"

module asp_serial_port #(
  parameter ADDR_W = 8
)(
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rxd,
  input wire t1_overflow,
  input wire t2_overflow,
  output reg txd,
  output wire serial_irq
);

  localparam RX_IDLE = 2'h0;
  localparam RX_BUSY = 2'h1;
  localparam RX_TAIL = 2'h2;

  function [7:0] asp_rev8;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        asp_rev8[i] = v[7 - i];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Control state.

  reg [1:0] mode_r;
  reg multiprocessor_filter_bit;
  reg ren_r;
  reg transmit_ninth_bit;
  reg received_ninth_bit;
  reg transmit_done_flag;
  reg receive_done_flag;
  reg rate_double_bit;
  reg tx_rate_source_select;
  reg rx_rate_source_select;
  reg [7:0] serial_buffer_reg;

  wire [7:0] serial_control_reg = {mode_r, multiprocessor_filter_bit, ren_r,
                                   transmit_ninth_bit, received_ninth_bit,
                                   transmit_done_flag, receive_done_flag};

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave.

  reg [31:0] rd_mux;
  reg addr_hit;
  wire tx_busy;
  wire rx_busy;

  // Zero wait states: pready only drops while the clock enable freezes the block.
  assign pready = clk_en;
  assign pslverr = psel & penable & ~addr_hit;

  wire wr_acc = psel & penable & pwrite & addr_hit;
  wire wr_ctrl = wr_acc & (paddr == `ASP_OFF_CTRL);
  wire wr_buf = wr_acc & (paddr == `ASP_OFF_BUF);
  wire wr_rate = wr_acc & (paddr == `ASP_OFF_RATE);

  always @*
  begin
    rd_mux = 32'h00000000;
    addr_hit = 1'b1;
    if (paddr == `ASP_OFF_CTRL)
      rd_mux = {24'h000000, serial_control_reg};
    else if (paddr == `ASP_OFF_BUF)
      rd_mux = {24'h000000, serial_buffer_reg};
    else if (paddr == `ASP_OFF_RATE)
      rd_mux = {29'h0, rx_rate_source_select, tx_rate_source_select,
                rate_double_bit};
    else if (paddr == `ASP_OFF_STAT)
      rd_mux = {30'h0, rx_busy, tx_busy};
    else
      addr_hit = 1'b0;
  end

  // Read data is captured in the setup cycle so it stays stable through access.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= `ASP_RD_RST;
    else if (clk_en && psel && !penable)
      prdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit-rate ticks at sixteen times the bit rate.

  reg [1:0] pre_r;
  reg t1_half_r;

  // Divide by 2 gives 1/32 of the oscillator, divide by 4 gives 1/64.
  wire osc_tick = rate_double_bit ? pre_r[0] : (pre_r == `ASP_PRE_LAST);
  wire t1_tick = t1_overflow & (rate_double_bit | t1_half_r);
  wire tx_tick = (mode_r == `ASP_MODE_2) ? osc_tick :
                 (tx_rate_source_select ? t2_overflow : t1_tick);
  wire rx_tick = (mode_r == `ASP_MODE_2) ? osc_tick :
                 (rx_rate_source_select ? t2_overflow : t1_tick);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_r <= 2'h0;
      t1_half_r <= 1'b0;
    end
    else if (clk_en)
    begin
      pre_r <= pre_r + 2'h1;
      if (t1_overflow)
        t1_half_r <= ~t1_half_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter.

  reg [3:0] tx_cnt_r;
  reg tx_pend_r;
  reg tx_send_r;
  reg tx_data_r;
  reg tx_shifted_r;
  reg [8:0] tsr_r;

  wire tx_en = (mode_r != `ASP_MODE_0);
  // The transmit counter runs whether or not a frame is queued, so a new frame
  // waits for its next rollover instead of starting at the buffer write.
  wire tx_roll = tx_tick & (tx_cnt_r == `ASP_CNT_LAST);
  // A write while a frame is pending or in flight is dropped to protect it.
  wire tx_load = wr_buf & ~tx_busy & tx_en;
  wire tx_ninth = (mode_r == `ASP_MODE_1) ? 1'b1 : transmit_ninth_bit;
  // The end pattern is only tested after the first shift, because a raw
  // ninth bit and data byte could mimic it before then.
  wire tx_last = tx_shifted_r & (tsr_r[8:1] == `ASP_TX_END_PAT);
  wire tx_done = tx_roll & tx_data_r & tx_last;
  wire tx_ins = ~tx_shifted_r & (mode_r != `ASP_MODE_1);
  wire txd_nxt = ~tx_send_r ? 1'b1 : (~tx_data_r ? 1'b0 : tsr_r[0]);

  assign tx_busy = tx_pend_r | tx_send_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_cnt_r <= `ASP_CNT_ZERO;
      tx_pend_r <= 1'b0;
      tx_send_r <= 1'b0;
      tx_data_r <= 1'b0;
      tx_shifted_r <= 1'b0;
      tsr_r <= `ASP_TSR_RST;
      txd <= 1'b1;
    end
    else if (clk_en)
    begin
      txd <= txd_nxt;
      if (tx_tick)
        tx_cnt_r <= tx_cnt_r + 4'h1;
      if (tx_load)
      begin
        tsr_r <= {tx_ninth, pwdata[7:0]};
        tx_pend_r <= 1'b1;
      end
      else if (tx_roll)
      begin
        if (tx_pend_r)
        begin
          tx_pend_r <= 1'b0;
          tx_send_r <= 1'b1;
        end
        else if (tx_send_r && !tx_data_r)
          tx_data_r <= 1'b1;
        else if (tx_data_r)
        begin
          tsr_r <= {tx_ins, tsr_r[8:1]};
          tx_shifted_r <= 1'b1;
          if (tx_last)
          begin
            tx_send_r <= 1'b0;
            tx_data_r <= 1'b0;
            tx_shifted_r <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver.

  reg [1:0] rx_state_r;
  reg [3:0] rx_cnt_r;
  reg rxd_prev_r;
  reg [2:0] samp_r;
  reg rx_first_r;
  reg [8:0] rsr_r;

  wire rx_en = ren_r & (mode_r != `ASP_MODE_0);
  // The edge is judged between consecutive ticks, so detection lags the line
  // by up to one tick; the mid-bit samples leave ample margin for that.
  wire rx_edge = rx_tick & rxd_prev_r & ~rxd;
  wire rx_roll = rx_tick & (rx_cnt_r == `ASP_CNT_LAST);
  wire rx_samp = rx_tick & ((rx_cnt_r == `ASP_SAMPLE_A) | (rx_cnt_r == `ASP_SAMPLE_B) |
                            (rx_cnt_r == `ASP_SAMPLE_C));
  wire rx_bit = (samp_r[0] & samp_r[1]) | (samp_r[0] & samp_r[2]) |
                (samp_r[1] & samp_r[2]);
  wire rx_final = rx_roll & (rx_state_r == RX_BUSY) & ~rx_first_r & ~rsr_r[8];
  // The last sampled bit is the stop bit in mode 1 and the ninth bit in modes 2
  // and 3, so one filter test covers both frame formats.
  wire rx_accept = rx_final & ~receive_done_flag &
                   (~multiprocessor_filter_bit | rx_bit);

  assign rx_busy = (rx_state_r != RX_IDLE);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r <= `ASP_CNT_ZERO;
      rxd_prev_r <= 1'b1;
      samp_r <= `ASP_SAMP_RST;
      rx_first_r <= 1'b0;
      rsr_r <= `ASP_RSR_INIT;
    end
    else if (clk_en)
    begin
      if (rx_tick)
        rxd_prev_r <= rxd;
      if (rx_samp)
        samp_r <= {samp_r[1:0], rxd};
      if (!rx_en)
        rx_state_r <= RX_IDLE;
      else
      begin
        case (rx_state_r)
          RX_IDLE:
          begin
            if (rx_edge)
            begin
              rx_cnt_r <= `ASP_CNT_ZERO;
              rsr_r <= `ASP_RSR_INIT;
              rx_first_r <= 1'b1;
              rx_state_r <= RX_BUSY;
            end
            else if (rx_tick)
              rx_cnt_r <= rx_cnt_r + 4'h1;
          end
          RX_BUSY:
          begin
            if (rx_tick)
              rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_roll)
            begin
              if (rx_first_r && rx_bit)
                rx_state_r <= RX_IDLE;
              else
              begin
                rsr_r <= {rsr_r[7:0], rx_bit};
                rx_first_r <= 1'b0;
                if (rx_final)
                  rx_state_r <= (mode_r == `ASP_MODE_1) ? RX_IDLE : RX_TAIL;
              end
            end
          end
          RX_TAIL:
          begin
            // The stop bit time of modes 2 and 3 is sat out but not checked.
            if (rx_tick)
              rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_roll)
              rx_state_r <= RX_IDLE;
          end
          default:
            rx_state_r <= RX_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers written by software, updated by the serial logic, or both.

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r <= `ASP_MODE_RST;
      multiprocessor_filter_bit <= 1'b0;
      ren_r <= 1'b0;
      transmit_ninth_bit <= 1'b0;
      received_ninth_bit <= 1'b0;
      transmit_done_flag <= 1'b0;
      receive_done_flag <= 1'b0;
      rate_double_bit <= 1'b0;
      tx_rate_source_select <= 1'b0;
      rx_rate_source_select <= 1'b0;
      serial_buffer_reg <= `ASP_BUF_RST;
    end
    else if (clk_en)
    begin
      if (wr_ctrl)
      begin
        mode_r <= pwdata[`ASP_CTRL_MODE_HI:`ASP_CTRL_MODE_LO];
        multiprocessor_filter_bit <= pwdata[`ASP_CTRL_FILTER];
        ren_r <= pwdata[`ASP_CTRL_REN];
        transmit_ninth_bit <= pwdata[`ASP_CTRL_TX_NINTH];
      end
      if (wr_rate)
      begin
        rate_double_bit <= pwdata[`ASP_RATE_DOUBLE];
        tx_rate_source_select <= pwdata[`ASP_RATE_TX_SRC];
        rx_rate_source_select <= pwdata[`ASP_RATE_RX_SRC];
      end
      // Hardware events win over a software write in the same cycle.
      if (rx_accept)
      begin
        serial_buffer_reg <= asp_rev8(rsr_r[7:0]);
        received_ninth_bit <= rx_bit;
        receive_done_flag <= 1'b1;
      end
      else if (wr_ctrl)
      begin
        received_ninth_bit <= pwdata[`ASP_CTRL_RX_NINTH];
        receive_done_flag <= pwdata[`ASP_CTRL_RX_DONE];
      end
      if (tx_done)
        transmit_done_flag <= 1'b1;
      else if (wr_ctrl)
        transmit_done_flag <= pwdata[`ASP_CTRL_TX_DONE];
    end
  end

  // The flags stay set until software clears them, so the request is a level.
  assign serial_irq = receive_done_flag | transmit_done_flag;

endmodule

//--- test/asp_remote.sv
`timescale 1ns/100ps
module asp_remote(
  input wire pclk,
  input wire txd,
  output reg rxd
);
  initial rxd = 1'b1;
  // Bits after the low start bit go LSB first; the line is left high between frames.
  task send(input [9:0] f, input int n, input int bl);
    integer i;
    rxd <= 1'b0;
    repeat (bl) @(posedge pclk);
    for (i = 0; i < n; i++)
    begin
      rxd <= f[i];
      repeat (bl) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
  // Sampling at mid-bit tolerates the one-cycle lag of the serial output.
  task recv(output [10:0] v, input int n, input int bl);
    integer i;
    v = 11'h000;
    while (txd !== 1'b0) @(posedge pclk);
    repeat (bl / 2) @(posedge pclk);
    for (i = 0; i <= n; i++)
    begin
      v[i] = txd;
      repeat (bl) @(posedge pclk);
    end
  endtask
endmodule

//--- test/asp_serial_port_monitor.sv
`timescale 1ns/100ps
`include "asp_map.vh"
module asp_serial_port_monitor #(parameter ADDR_W = 8)(
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rxd,
  input wire t1_overflow,
  input wire t2_overflow,
  input wire txd,
  input wire serial_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire ctl_wr = acc && pready && pwrite && paddr == `ASP_OFF_CTRL;
  wire mapped = paddr == `ASP_OFF_CTRL || paddr == `ASP_OFF_BUF
    || paddr == `ASP_OFF_RATE || paddr == `ASP_OFF_STAT;
  property p_ready; pready == clk_en; endproperty
  a_ready: assert property (p_ready) else $error("pready differs from clk_en");
  property p_err; pslverr |-> acc && !mapped; endproperty
  a_err: assert property (p_err) else $error("pslverr on mapped or idle");
  property p_map; acc && mapped |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("pslverr on mapped address");
  property p_unm; acc && !pwrite && !mapped |-> prdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_irq_set; ctl_wr && pwdata[`ASP_CTRL_TX_DONE] |=> serial_irq; endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq not set by flag");
  property p_irq_hold; serial_irq && !ctl_wr |=> serial_irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  property p_idle; $rose(presetn) |-> txd && !serial_irq; endproperty
  a_idle: assert property (p_idle) else $error("txd low after reset");
  // Timer overflow inputs can tick every clock, so no bit is shorter than 16 clocks.
  property p_start; $fell(txd) |=> !txd [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  property p_frz; !clk_en |=> $stable(txd) && $stable(serial_irq); endproperty
  a_frz: assert property (p_frz) else $error("state moved while frozen");
  c_tx: cover property ($fell(txd));
  c_irq: cover property ($rose(serial_irq));
  c_err: cover property (pslverr);
endmodule
bind asp_serial_port asp_serial_port_monitor #(.ADDR_W(ADDR_W)) asp_monitor_inst(.pclk, .presetn,
  .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd,
  .t1_overflow, .t2_overflow, .txd, .serial_irq);

//--- test/asp_serial_port_bench.sv
`timescale 1ns/100ps
`include "asp_map.vh"
module asp_serial_port_bench;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg clk_en = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg t1_overflow = 1'b0;
  reg t2_overflow = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, rxd, txd, serial_irq;
  integer error_cnt = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] q;
  reg e;
  reg [10:0] v;
  asp_serial_port asp_serial_port_inst(.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .t1_overflow, .t2_overflow, .txd,
    .serial_irq);
  asp_remote asp_remote_inst(.pclk, .txd, .rxd);
  initial forever #2 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Timer pulses run all the time so both sources are always live.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    t1_overflow <= (cyc % 2 == 0);
    t2_overflow <= (cyc % 4 == 0);
    if (cyc == 30000)
    begin
      error_cnt = error_cnt + 1;
      results;
    end
  end
  task check(input string n, input [31:0] s, input [31:0] x);
    check_count++;
    if (s !== x)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////
  task tx_case(input [7:0] c, input [7:0] r, input [7:0] d, input int bl);
    integer n, k;
    reg [10:0] x;
    n = (c[7:6] == `ASP_MODE_1) ? 9 : 10;
    x = (n == 9) ? {2'b01, d, 1'b0} : {1'b1, c[3], d, 1'b0};
    apb(1, `ASP_OFF_RATE, r);
    apb(1, `ASP_OFF_CTRL, c);
    apb(1, `ASP_OFF_BUF, d);
    k = 0;
    fork
      asp_remote_inst.recv(v, n, bl);
      while (serial_irq !== 1'b1)
      begin
        @(posedge pclk);
        k++;
      end
    join
    check("txbits", v, x);
    check("txtime", k > n * bl - 4 && k <= (n + 1) * bl + 4, 1);
    apb(0, `ASP_OFF_CTRL, 0);
    check("tx_done", q, c | 8'h02);
    apb(1, `ASP_OFF_CTRL, c);
    @(posedge pclk);
    check("irq", serial_irq, 0);
  endtask
  // Reading only after one more bit time also covers the mode 1 load at the end of its stop bit.
  task rx_case(input [7:0] c, r, input [9:0] f, input int n, bl, input [7:0] b, x);
    apb(1, `ASP_OFF_RATE, r);
    apb(1, `ASP_OFF_CTRL, c);
    asp_remote_inst.send(f, n, bl);
    repeat (bl) @(posedge pclk);
    apb(0, `ASP_OFF_BUF, 0);
    check("rxbuf", q, b);
    apb(0, `ASP_OFF_CTRL, 0);
    check("rxctl", q, x);
    check("irq", serial_irq, x[0]);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check("txd", txd, 1);
    for (i = 0; i < 5; i++)
    begin
      apb(0, 8'(i * 4), 0);
      check("rst", q, 0);
      check("err", e, i == 4);
    end
    // Software may raise a flag itself; the request must follow it.
    apb(1, `ASP_OFF_CTRL, 32'h02);
    apb(0, `ASP_OFF_CTRL, 0);
    check("sw_flag", q, 32'h02);
    check("irq", serial_irq, 1);
    apb(1, `ASP_OFF_CTRL, 0);
    @(posedge pclk);
    check("irq", serial_irq, 0);
    clk_en <= 1'b0;
    repeat (5) @(posedge pclk);
    clk_en <= 1'b1;
    tx_case(8'h88, 8'h00, 8'hA5, 64);
    tx_case(8'h80, 8'h01, 8'h5A, 32);
    tx_case(8'h40, 8'h00, 8'h80, 64);
    tx_case(8'hC0, 8'h02, 8'h3C, 64);
    rx_case(8'h50, 8'h01, {2'b01, 8'h3C}, 9, 32, 8'h3C, 8'h55);
    rx_case(8'h55, 8'h01, {2'b01, 8'hC3}, 9, 32, 8'h3C, 8'h55);
    rx_case(8'h70, 8'h01, {2'b00, 8'h77}, 9, 32, 8'h3C, 8'h70);
    rx_case(8'hF0, 8'h04, {2'b10, 8'h99}, 10, 64, 8'h3C, 8'hF0);
    rx_case(8'hF0, 8'h04, {2'b11, 8'h99}, 10, 64, 8'h99, 8'hF5);
    rx_case(8'h90, 8'h01, {2'b00, 8'h12}, 10, 32, 8'h12, 8'h91);
    asp_remote_inst.send(10'h000, 0, 8);
    repeat (64) @(posedge pclk);
    rx_case(8'h90, 8'h01, {2'b11, 8'h6E}, 10, 32, 8'h6E, 8'h95);
    results;
  end
endmodule
